// ==== design/ecb_bank.v ====
/*
 * receive error counter bank: framing alignment error count,
 * severely errored frame count and sync bit error count, all
 * cleared on read, behind an apb slave with one wait state.
 * assumes: error strobes come from framer logic on pclk, one cycle
 * wide; the host reads upper bytes before lower bytes.
 */
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "ecb_defs.vh"

// What this block does
// - 16-bit framing error count, low byte after upper
// - framing error count increments per detected error
// - counters hold errors since read, clear on read
// - upper then lower read clears whole count
// - 8-bit severely errored frame counter, clear on read
// - two consecutive bad alignment words, no frame loss
// - 16-bit sync bit error count, two addresses
// - sync bit error count increments per detected error
// - upper byte bits 15..8, lower byte 7..0

// ----------------------------------------------------------------
// saturating counter with clear-on-read
// ----------------------------------------------------------------
module ecb_cnt #(
	parameter W = 8
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         inc,
	input  wire         clr,
	output reg  [W-1:0] cnt_r
);

	wire [W-1:0] cnt_nxt;
	wire         full;

	// saturate rather than wrap: a wrapped count reads as few errors
	assign full    = &cnt_r;
	assign cnt_nxt = clr  ? {{(W-1){1'b0}}, inc} :   // clear wins; a same-cycle increment restarts the count at 1
	                 (inc && !full) ? cnt_r + {{(W-1){1'b0}}, 1'b1} :
	                 cnt_r;

	// count register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= {W{1'b0}};
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// ----------------------------------------------------------------
// bank top: apb slave, error qualification, counters
// ----------------------------------------------------------------
module ecb_bank #(
	parameter CNT_W = `ECB_WIDE_W,
	parameter SEF_W = `ECB_BYTE_W
) (
	input  wire                     pclk,
	input  wire                     presetn,
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [`ECB_ADDR_W-1:0]   paddr,
	input  wire [`ECB_DATA_W-1:0]   pwdata,
	input  wire [3:0]               pstrb,
	output reg  [`ECB_DATA_W-1:0]   prdata,
	output reg                      pready,
	output reg                      pslverr,
	input  wire                     fa_err_stb,
	input  wire                     fas_chk_stb,
	input  wire                     fas_chk_bad,
	input  wire                     loss_of_frame,
	input  wire                     sbe_err_stb
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	wire                     acc;
	wire                     rd;
	wire                     wr;
	wire [`ECB_IDX_W-1:0]    idx;
	wire                     hit_fa_hi;
	wire                     hit_fa_lo;
	wire                     hit_sef;
	wire                     hit_sbe_hi;
	wire                     hit_sbe_lo;
	wire                     hit_ctrl;
	wire                     mapped;
	wire                     fa_inc;
	wire                     sef_inc;
	wire                     sbe_inc;
	wire                     fa_clr;
	wire                     sef_clr;
	wire                     sbe_clr;
	wire [CNT_W-1:0]         fa_cnt;
	wire [SEF_W-1:0]         sef_cnt;
	wire [CNT_W-1:0]         sbe_cnt;
	reg  [`ECB_CTRL_W-1:0]   ctrl_r;
	reg  [`ECB_CTRL_W-1:0]   ctrl_nxt;
	reg                      prev_bad_r;
	reg                      prev_bad_nxt;
	reg  [`ECB_BYTE_W-1:0]   fa_snap_r;
	reg                      fa_snap_v_r;
	reg  [`ECB_BYTE_W-1:0]   sbe_snap_r;
	reg                      sbe_snap_v_r;
	reg  [`ECB_DATA_W-1:0]   rdata_nxt;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// first access cycle only; pready high ends the transfer next edge
	assign acc = psel && penable && !pready;
	assign rd  = acc && !pwrite;
	assign wr  = acc && pwrite;
	assign idx = paddr[`ECB_ADDR_IDX_HI:`ECB_ADDR_IDX_LO];

	assign hit_fa_hi  = (idx == `ECB_IDX_FA_HIGH);
	assign hit_fa_lo  = (idx == `ECB_IDX_FA_LOW);
	assign hit_sef    = (idx == `ECB_IDX_SEF);
	assign hit_sbe_hi = (idx == `ECB_IDX_SBE_HIGH);
	assign hit_sbe_lo = (idx == `ECB_IDX_SBE_LOW);
	assign hit_ctrl   = (idx == `ECB_IDX_CTRL);
	assign mapped     = hit_fa_hi | hit_fa_lo | hit_sef |
	                    hit_sbe_hi | hit_sbe_lo | hit_ctrl;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// only byte lane 0 carries bits; other lanes are ignored
	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr && hit_ctrl && pstrb[0]) begin
			ctrl_nxt = pwdata[`ECB_CTRL_W-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `ECB_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ------------------------------------------------------------
	// severely errored frame qualification
	// ------------------------------------------------------------
	// a pair counts once; the tracker restarts after each counted
	// pair so three bad words in a row give one event, not two
	assign sef_inc = fas_chk_stb && fas_chk_bad && prev_bad_r &&
	                 !loss_of_frame &&
	                 ctrl_r[`ECB_CTRL_SEF_EN];

	always @* begin
		prev_bad_nxt = prev_bad_r;
		if (loss_of_frame) begin
			prev_bad_nxt = 1'b0;
		end else if (fas_chk_stb) begin
			prev_bad_nxt = fas_chk_bad && !prev_bad_r;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_bad_r <= 1'b0;
		end else begin
			prev_bad_r <= prev_bad_nxt;
		end
	end

	// ------------------------------------------------------------
	// increment and clear terms
	// ------------------------------------------------------------
	assign fa_inc  = fa_err_stb  && ctrl_r[`ECB_CTRL_FA_EN];
	assign sbe_inc = sbe_err_stb && ctrl_r[`ECB_CTRL_SBE_EN];

	// upper read clears the whole count once its low byte is saved;
	// a lone low read (wrong order) clears the whole count, upper byte included
	assign fa_clr  = rd && (hit_fa_hi ||
	                 (hit_fa_lo && !fa_snap_v_r));
	assign sbe_clr = rd && (hit_sbe_hi ||
	                 (hit_sbe_lo && !sbe_snap_v_r));
	assign sef_clr = rd && hit_sef;

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	ecb_cnt #(
		.W       (CNT_W)
	) u_fa_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.inc     (fa_inc),
		.clr     (fa_clr),
		.cnt_r   (fa_cnt)
	);

	ecb_cnt #(
		.W       (SEF_W)
	) u_sef_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.inc     (sef_inc),
		.clr     (sef_clr),
		.cnt_r   (sef_cnt)
	);

	ecb_cnt #(
		.W       (CNT_W)
	) u_sbe_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.inc     (sbe_inc),
		.clr     (sbe_clr),
		.cnt_r   (sbe_cnt)
	);

	// ------------------------------------------------------------
	// low-byte snapshots
	// ------------------------------------------------------------
	// the live counter keeps counting after the upper read, so the
	// lower read must return the byte frozen with the upper one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fa_snap_r    <= `ECB_CNT_RST;
			fa_snap_v_r  <= 1'b0;
		end else if (rd && hit_fa_hi) begin
			fa_snap_r    <= fa_cnt[`ECB_LO_MSB:`ECB_LO_LSB];
			fa_snap_v_r  <= 1'b1;
		end else if (rd && hit_fa_lo) begin
			fa_snap_v_r  <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sbe_snap_r   <= `ECB_CNT_RST;
			sbe_snap_v_r <= 1'b0;
		end else if (rd && hit_sbe_hi) begin
			sbe_snap_r   <= sbe_cnt[`ECB_LO_MSB:`ECB_LO_LSB];
			sbe_snap_v_r <= 1'b1;
		end else if (rd && hit_sbe_lo) begin
			sbe_snap_v_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------
	always @* begin
		rdata_nxt = `ECB_WORD_ZERO;
		if (hit_fa_hi) begin
			rdata_nxt[`ECB_LO_MSB:`ECB_LO_LSB] =
				fa_cnt[`ECB_HI_MSB:`ECB_HI_LSB];
		end else if (hit_fa_lo) begin
			rdata_nxt[`ECB_LO_MSB:`ECB_LO_LSB] = fa_snap_v_r ?
				fa_snap_r : fa_cnt[`ECB_LO_MSB:`ECB_LO_LSB];
		end else if (hit_sef) begin
			rdata_nxt[`ECB_LO_MSB:`ECB_LO_LSB] = sef_cnt;
		end else if (hit_sbe_hi) begin
			rdata_nxt[`ECB_LO_MSB:`ECB_LO_LSB] =
				sbe_cnt[`ECB_HI_MSB:`ECB_HI_LSB];
		end else if (hit_sbe_lo) begin
			rdata_nxt[`ECB_LO_MSB:`ECB_LO_LSB] = sbe_snap_v_r ?
				sbe_snap_r : sbe_cnt[`ECB_LO_MSB:`ECB_LO_LSB];
		end else if (hit_ctrl) begin
			rdata_nxt[`ECB_CTRL_W-1:0] = ctrl_r;
		end
	end

	// ------------------------------------------------------------
	// apb response registers
	// ------------------------------------------------------------
	// one wait state: pready rises on the edge after the first
	// access cycle and drops on the edge that completes the transfer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `ECB_WORD_ZERO;
		end else if (acc) begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= pwrite ? `ECB_WORD_ZERO : rdata_nxt;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

// ==== design/ecb_defs.vh ====
/*
 * register indices, field positions, reset values and bus constants
 * for the receive error counter bank.
 * assumes: included by the bank's design file and the bench checker; definitions only.
 */
`ifndef ECB_DEFS_VH
`define ECB_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ECB_IDX_W            14
`define ECB_IDX_FA_HIGH      14'h0902
`define ECB_IDX_FA_LOW       14'h0903
`define ECB_IDX_SEF          14'h0904
`define ECB_IDX_SBE_HIGH     14'h0905
`define ECB_IDX_SBE_LOW      14'h0906
`define ECB_IDX_CTRL         14'h0910

// ----------------------------------------------------------------
// apb address fields
// ----------------------------------------------------------------
`define ECB_ADDR_W           16
`define ECB_ADDR_IDX_HI      15
`define ECB_ADDR_IDX_LO      2
`define ECB_DATA_W           32

// ----------------------------------------------------------------
// counter layout
// ----------------------------------------------------------------
`define ECB_BYTE_W           8
`define ECB_WIDE_W           16
`define ECB_HI_MSB           15
`define ECB_HI_LSB           8
`define ECB_LO_MSB           7
`define ECB_LO_LSB           0

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define ECB_CTRL_W           3
`define ECB_CTRL_FA_EN       0
`define ECB_CTRL_SEF_EN      1
`define ECB_CTRL_SBE_EN      2
`define ECB_CTRL_RST         3'h7
`define ECB_CNT_RST          8'h00
`define ECB_WORD_ZERO        32'h0000_0000

`endif

// ==== testbench/ecb_bank_tb_top.sv ====
/* bench top: drives the bank over apb, framer model on the error side.
   assumes: ecb_defs.vh on the include path. */
`timescale 1ns/1ps
module ecb_bank_tb_top;
	localparam [15:0] FAH = 16'h2408, FAL = 16'h240c, SEF = 16'h2410;
	localparam [15:0] SBH = 16'h2414, SBL = 16'h2418, CTL = 16'h2440;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 0;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr;
	wire         fa_err_stb, fas_chk_stb, fas_chk_bad, loss_of_frame, sbe_err_stb;
	int          err_total = 0, tests_run = 0;
	// --------
	// clock, parts
	// --------
	always #10 pclk = ~pclk;
	ecb_bank DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .fa_err_stb, .fas_chk_stb, .fas_chk_bad,
		.loss_of_frame, .sbe_err_stb);
	ecb_framer_model fm (.pclk, .fa_err_stb, .fas_chk_stb, .fas_chk_bad, .loss_of_frame,
		.sbe_err_stb);
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string what, input [31:0] exp, input [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] %s exp %h got %h", what, exp, got);
			err_total++;
		end
	endtask
	// request held until ready is seen high at an edge
	task apb(input bit w, input [15:0] a, input [31:0] d, output [31:0] rd, output e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("ready wait", 0, n >= 20);
		rd = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rdc(input [15:0] a, input [31:0] exp, input string what);
		logic [31:0] rd;
		logic        e;
		apb(0, a, 0, rd, e);
		chk({what, " err"}, 0, e);
		chk(what, exp, rd);
	endtask
	// --------
	// scenarios
	// --------
	task t_reset;
		logic [15:0] ca[5] = '{FAH, FAL, SEF, SBH, SBL};
		logic [31:0] rd;
		logic        e;
		foreach (ca[i]) rdc(ca[i], 0, "count");
		rdc(CTL, 32'h7, "ctrl");
		apb(0, 16'h2420, 0, rd, e);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, rd);
		$display("t_reset done");
	endtask
	// count above one byte: high, then low, then both clear
	task t_pair(input bit sbe, input [15:0] hi, input int n);
		fm.errs(sbe, n, 0);
		rdc(hi, n >> 8, "high");
		rdc(hi + 16'h4, n & 8'hff, "low");
		rdc(hi, 0, "high clr");
		rdc(hi + 16'h4, 0, "low clr");
		$display("t_pair done");
	endtask
	// errors between the two byte reads must survive
	task t_snap;
		fm.errs(1, 5, 1);
		rdc(SBH, 0, "snap high");
		fm.errs(1, 3, 0);
		rdc(SBL, 5, "frozen low");
		rdc(SBH, 0, "kept high");
		rdc(SBL, 3, "kept low");
		$display("t_snap done");
	endtask
	task t_sef;
		bit pat[8] = '{1, 1, 0, 1, 0, 1, 1, 1};
		foreach (pat[i]) fm.fas(pat[i]);
		fm.lof(1);
		fm.fas(1);
		fm.fas(1);
		fm.lof(0);
		fm.fas(1);
		rdc(SEF, 2, "sef");
		rdc(SEF, 0, "sef clr");
		$display("t_sef done");
	endtask
	// disabled counting, then a write to a counter that must not land
	task t_ctrl;
		logic [31:0] rd;
		logic        e;
		apb(1, CTL, 0, rd, e);
		chk("wr data", 0, rd);
		fm.errs(0, 4, 0);
		fm.errs(1, 4, 0);
		fm.fas(1);
		fm.fas(1);
		rdc(FAL, 0, "fa off");
		rdc(SBL, 0, "sbe off");
		rdc(SEF, 0, "sef off");
		apb(1, CTL, 32'h7, rd, e);
		// lane 0 strobe low: the control write must not land
		pstrb <= 4'he;
		apb(1, CTL, 0, rd, e);
		pstrb <= 4'hf;
		rdc(CTL, 32'h7, "ctrl strb");
		apb(1, FAL, 32'h55, rd, e);
		chk("wr cnt err", 0, e);
		fm.errs(0, 2, 1);
		rdc(FAH, 0, "fa on high");
		rdc(FAL, 2, "fa on low");
		$display("t_ctrl done");
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_pair(0, FAH, 300);
		t_pair(1, SBH, 515);
		t_snap;
		t_sef;
		t_ctrl;
		close_out;
	end
	// watchdog, far beyond the few thousand cycles needed
	initial begin
		#400000;
		err_total++;
		close_out;
	end
endmodule
bind ecb_bank ecb_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr);

// ==== testbench/ecb_checker.sv ====
/* checker: bus timing and error answers of the counter bank.
   assumes: bound to ecb_bank from the testbench top. */
`timescale 1ns/1ps
`include "ecb_defs.vh"
module ecb_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [15:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr
);
	// --------
	// decode
	// --------
	wire [13:0] idx = paddr[15:2];
	// only the counter words and the control word answer cleanly
	wire mapped = (idx >= `ECB_IDX_FA_HIGH && idx <= `ECB_IDX_SBE_LOW) || idx == `ECB_IDX_CTRL;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// first access cycle as a plain expression, so it can be combined with &&
	wire take = psel && penable && !pready;
	sequence s_take;
		take;
	endsequence
	sequence s_wr_done;
		take && pwrite ##1 pready;
	endsequence
	a_ready_one_wait: assert property (s_take |=> pready)
		else $error("no answer one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	a_ready_cause: assert property (pready |-> $past(psel && penable && !pready))
		else $error("ready without access");
	a_unmapped_err: assert property (take && !mapped |=> pready && pslverr)
		else $error("unmapped word not refused");
	a_mapped_ok: assert property (take && mapped |=> !pslverr)
		else $error("mapped word refused");
	a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read data not zero");
	a_byte_lane: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_write_zero: assert property (s_wr_done |-> prdata == 32'h0)
		else $error("write returned data");
endmodule

// ==== testbench/ecb_framer_model.sv ====
/* framer side: one-cycle error strobes and frame check pulses.
   assumes: the bench calls one task at a time. */
`timescale 1ns/1ps
module ecb_framer_model (
	input  wire  pclk,
	output logic fa_err_stb,
	output logic fas_chk_stb,
	output logic fas_chk_bad,
	output logic loss_of_frame,
	output logic sbe_err_stb
);
	// --------
	// strobes
	// --------
	// quiet lines from time zero
	initial begin
		fa_err_stb = 1'h0;
		fas_chk_stb = 1'h0;
		fas_chk_bad = 1'h0;
		loss_of_frame = 1'h0;
		sbe_err_stb = 1'h0;
	end
	// n error pulses, gap+1 idle cycles apart
	task errs(input bit sbe, input int n, input int gap);
		repeat (n) begin
			@(posedge pclk);
			if (sbe) sbe_err_stb <= 1'h1;
			else fa_err_stb <= 1'h1;
			@(posedge pclk);
			sbe_err_stb <= 1'h0;
			fa_err_stb <= 1'h0;
			repeat (gap) @(posedge pclk);
		end
	endtask
	// unqualified check line shows the inverse, not a stale value
	task fas(input bit bad);
		@(posedge pclk);
		fas_chk_stb <= 1'h1;
		fas_chk_bad <= bad;
		@(posedge pclk);
		fas_chk_stb <= 1'h0;
		fas_chk_bad <= ~bad;
	endtask
	task lof(input bit v);
		@(posedge pclk);
		loss_of_frame <= v;
	endtask
endmodule
